// [rtl/tmr_pkg.sv]
// Constants, register map and types for the 8-bit timer/counter block
// Function
// - 8-bit count register, readable and writable by software.
// - Timer mode without prescaler increments once every instruction cycle.
// - Clock-source select cleared to zero selects timer mode.
// - Increments are suppressed for two cycles after a count register write.
// - Counter mode increments on the selected edge of the external pin.
// - Clock-source select set to one selects counter mode.
// - One prescaler, owned by timer or watchdog; zero gives it to timer.
// - Timer owner: three-bit rate field selects 1:2 up to 1:256.
// - 1:1 timer rate only by giving the prescaler to the watchdog.
// - Prescaler count is never readable or writable by software.
// - Timer owner: every count register write clears the prescaler.
// - Watchdog owner: watchdog clear resets prescaler and watchdog counter.
// - Edge select one counts falling edges, zero counts rising edges.
// - Rate codes double per step: timer 1:2..1:256, watchdog 1:1..1:128.
// - Wrap from ff to 00 sets overflow flag; only software clears it.
// - Counter mode samples the prescaler output on the internal clock; the code samples the pin before the prescaler and never resamples its output.
package tmr_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned PRE_W       = 8;
  localparam int unsigned RATE_W      = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] OPTION_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 8'h0c;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h10;

  // Option register fields
  localparam int unsigned CSS_BIT   = 5;
  localparam int unsigned SES_BIT   = 4;
  localparam int unsigned OWNER_BIT = 3;
  localparam int unsigned RATE_LSB  = 0;
  localparam int unsigned OPT_W     = 6;
  localparam logic [OPT_W-1:0] OPTION_RST = 6'h3f;

  // Status, mask and control fields
  localparam int unsigned OVF_BIT    = 0;
  localparam int unsigned WDCLR_BIT  = 0;
  localparam logic        MASK_RST   = 1'h0;

  // Cycles of suppressed counting after a count write
  localparam logic [1:0] INHIBIT_CYC = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              clock_source_select;
    logic              source_edge_select;
    logic              prescaler_owner_select;
    logic [RATE_W-1:0] prescale_rate_field;
  } option_s;

endpackage

// [rtl/tmr_core.sv]
// 8-bit timer/counter with shared prescaler behind an AXI4-Lite slave
`timescale 1ns/1ps
module tmr_core
  import tmr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              external_count_pin,
  input  wire logic              watchdog_tick,
  output logic                   watchdog_prescaled_tick,
  output logic                   watchdog_clear,
  output logic                   irq
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic              wlane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic [CNT_W-1:0]  count_register;
    option_s           option;
    logic [PRE_W-1:0]  prescaler;
    logic [1:0]        inhibit;
    logic              pin_prev;
    logic              overflow_flag;
    logic              ovf_mask;
    logic              wd_tick_out;
    logic              wd_clear;
    logic              irq;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Decoded write, event sources and prescaler terms
  logic              wr_go;
  logic              wr_count;
  logic              wr_option;
  logic              wr_status;
  logic              wr_mask;
  logic              wr_ctrl;
  logic              pin_edge;
  logic              src_event;
  logic              pre_in;
  logic              pre_out;
  logic              timer_owns;
  logic [PRE_W-1:0]  pre_inc;
  logic [PRE_W-1:0]  pre_mask;
  logic              cnt_step;
  logic              ovf_event;
  logic              ar_go;
  logic              ar_hit;
  logic [DATA_W-1:0] rd_word;

  always_comb
  begin
    st_nxt     = st_r;
    timer_owns = !st_r.option.prescaler_owner_select;

    // Write commits only once both address and data are held
    wr_go     = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    wr_count  = wr_go && st_r.wlane0 && (st_r.awaddr == COUNT_OFS);
    wr_option = wr_go && st_r.wlane0 && (st_r.awaddr == OPTION_OFS);
    wr_status = wr_go && st_r.wlane0 && (st_r.awaddr == STATUS_OFS);
    wr_mask   = wr_go && st_r.wlane0 && (st_r.awaddr == MASK_OFS);
    wr_ctrl   = wr_go && st_r.wlane0 && (st_r.awaddr == CTRL_OFS);

    // Pin is already synchronous; one flop of history finds the edge
    if (st_r.option.source_edge_select)
      pin_edge = st_r.pin_prev && !external_count_pin;
    else
      pin_edge = !st_r.pin_prev && external_count_pin;

    // Counter mode picks pin edges, timer mode every cycle
    if (st_r.option.clock_source_select)
      src_event = pin_edge;
    else
      src_event = 1'b1;

    // Events landing inside the inhibit window are dropped outright
    if (st_r.inhibit != 2'h0)
      src_event = 1'b0;

    // Prescaler input follows its owner
    pre_in  = timer_owns ? src_event : watchdog_tick;
    pre_inc = st_r.prescaler + PRE_W'(1);
    // Timer ratio is 2^(code+1), watchdog ratio 2^code
    if (timer_owns)
      pre_mask = PRE_W'((9'h002 << st_r.option.prescale_rate_field)
                        - 9'h001);
    else
      pre_mask = PRE_W'((9'h001 << st_r.option.prescale_rate_field)
                        - 9'h001);
    pre_out = pre_in && ((st_r.prescaler & pre_mask) == pre_mask);

    // Not resampled, so a divided pin edge steps the count on the same edge as an undivided one
    if (timer_owns)
      cnt_step = pre_out;
    else
      cnt_step = src_event;

    if (pre_in)
      st_nxt.prescaler = pre_out ? '0 : pre_inc;
    // Clearing on a count write keeps the first period a full one
    if (wr_count && timer_owns)
      st_nxt.prescaler = '0;
    if (wr_ctrl && st_r.wdata[WDCLR_BIT] && !timer_owns)
      st_nxt.prescaler = '0;
    st_nxt.wd_tick_out = !timer_owns && pre_out;
    st_nxt.wd_clear    = wr_ctrl && st_r.wdata[WDCLR_BIT];
    st_nxt.pin_prev    = external_count_pin;

    // Count register; a software write wins over an increment
    ovf_event = cnt_step && (st_r.count_register == 8'hff);
    if (cnt_step)
      st_nxt.count_register = st_r.count_register + CNT_W'(1);
    if (st_r.inhibit != 2'h0)
      st_nxt.inhibit = st_r.inhibit - 2'h1;
    if (wr_count)
    begin
      st_nxt.count_register = st_r.wdata[CNT_W-1:0];
      st_nxt.inhibit        = INHIBIT_CYC;
    end

    if (wr_option)
      st_nxt.option = option_s'(st_r.wdata[OPT_W-1:0]);
    if (wr_mask)
      st_nxt.ovf_mask = st_r.wdata[OVF_BIT];
    // Write one to clear; a same-cycle overflow keeps the flag set
    if (wr_status && st_r.wdata[OVF_BIT])
      st_nxt.overflow_flag = 1'b0;
    if (ovf_event)
      st_nxt.overflow_flag = 1'b1;
    st_nxt.irq = st_nxt.overflow_flag && st_nxt.ovf_mask;

    // Write address and data channels, taken in either order
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wlane0 = s_axi_wstrb[0];
    end
    if (wr_go)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      case (st_r.awaddr)
        COUNT_OFS, OPTION_OFS, STATUS_OFS, MASK_OFS, CTRL_OFS:
          st_nxt.bresp = RESP_OKAY;
        default:
          st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;

    // Read channel; the prescaler count has no address at all
    ar_go  = s_axi_arvalid && st_r.arready;
    ar_hit = 1'b1;
    case (s_axi_araddr)
      COUNT_OFS:  rd_word = DATA_W'(st_r.count_register);
      OPTION_OFS: rd_word = DATA_W'(st_r.option);
      STATUS_OFS: rd_word = DATA_W'(st_r.overflow_flag);
      MASK_OFS:   rd_word = DATA_W'(st_r.ovf_mask);
      CTRL_OFS:   rd_word = '0;
      default:
      begin
        rd_word = '0;
        ar_hit  = 1'b0;
      end
    endcase
    if (ar_go)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_word;
      st_nxt.rresp  = ar_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    st_nxt.arready = !st_nxt.rvalid;
  end

  // Single state register; every field takes a constant at reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r        <= '0;
      st_r.option <= option_s'(OPTION_RST);
      st_r.ovf_mask <= MASK_RST;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs come straight from the state register
  assign s_axi_awready           = st_r.awready;
  assign s_axi_wready            = st_r.wready;
  assign s_axi_bvalid            = st_r.bvalid;
  assign s_axi_bresp             = st_r.bresp;
  assign s_axi_arready           = st_r.arready;
  assign s_axi_rvalid            = st_r.rvalid;
  assign s_axi_rdata             = st_r.rdata;
  assign s_axi_rresp             = st_r.rresp;
  assign watchdog_prescaled_tick = st_r.wd_tick_out;
  assign watchdog_clear          = st_r.wd_clear;
  assign irq                     = st_r.irq;

endmodule

// [tb/tmr_chk.sv]
// Bus, pulse and read-data assertions for the timer/counter block
`timescale 1ns/1ps
module tmr_chk
  import tmr_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              watchdog_clear,
  input wire logic              watchdog_prescaled_tick,
  input wire logic              irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_answer: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_holds: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  a_write_holds: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before taken");
  a_ar_refused: assert property
    (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_upper_zero: assert property
    (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_err_data: assert property
    (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("refused read carries data");
  a_clear_pulse: assert property
    (watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than a cycle");
  a_tick_pulse: assert property
    (watchdog_prescaled_tick |=> !watchdog_prescaled_tick)
    else $error("prescaled tick longer than a cycle");

  // Main scenarios reached
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_irq: cover property ($rose(irq));
  c_clear: cover property (watchdog_clear);
endmodule

bind tmr_core tmr_chk chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .watchdog_clear(watchdog_clear), .irq(irq),
  .watchdog_prescaled_tick(watchdog_prescaled_tick)
);

// [tb/ext_src.sv]
// Far-side model: external count pin and watchdog time base
`timescale 1ns/1ps
module ext_src (
  input  wire logic aclk,
  output logic      pin,
  output logic      tick
);
  logic [2:0] div = 3'h0;
  initial
  begin
    pin = 1'b0;
    tick = 1'b0;
  end
  // Ticks every fifth cycle, so divided ticks can never merge
  always @(posedge aclk)
  begin
    div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
    tick <= (div == 3'h4);
  end
  // Level held long enough for the edge detector and the inhibit
  task automatic level(input logic v);
    repeat (4) @(posedge aclk);
    pin <= v;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// [tb/test_eight_bit_timer_counter_prescaler.sv]
// Self-checking bench for the timer/counter block
`timescale 1ns/1ps
module test_eight_bit_timer_counter_prescaler;
  import tmr_pkg::*;
  logic              aclk = 0, aresetn = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd;
  logic              awvalid = 0, wvalid = 0, bready = 0;
  logic              arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              wclr, wpt, irq, pin, tick;
  logic [1:0]        bresp, rresp, rr;
  int                errors = 0, checks_done = 0, cyc = 0, tc, tr, nclr = 0;
  int                nwpt = 0, ntick = 0, t0, w0, t1;
  logic [1:0]        br;
  logic [3:0]        wstrb = 4'hf;

  tmr_core DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rdata(rdata),
    .s_axi_arready(arready), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_count_pin(pin), .watchdog_tick(tick),
    .watchdog_prescaled_tick(wpt), .watchdog_clear(wclr), .irq(irq)
  );
  ext_src ext (.aclk(aclk), .pin(pin), .tick(tick));

  always #5 aclk = ~aclk;
  // Edge index and clear-pulse tally
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (wclr) nclr <= nclr + 1;
    if (wpt) nwpt <= nwpt + 1;
    if (tick) ntick <= ntick + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Write; tc is the commit edge, one before bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awready)
      begin
        ad = 1;
        awvalid <= 0;
      end
      if (wready)
      begin
        wd = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    br = bresp;
    tc = cyc - 1;
    bready <= 0;
  endtask

  // Read; tr is the address handshake edge
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    tr = cyc;
    arvalid <= 0;
    rready <= 1;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 0;
  endtask

  task automatic t_reset;
    rdr(OPTION_OFS);
    chk(rd, 32'h3f);
    chk(rr, RESP_OKAY);
    rdr(COUNT_OFS);
    chk(rd, 32'h0);
    rdr(MASK_OFS);
    chk(rd, 32'h0);
  endtask

  // Every rate code, then the watchdog-owned 1:1 case
  task automatic t_rate;
    for (int i = 0; i < 9; i++)
    begin
      wr(OPTION_OFS, (i == 8) ? 32'h08 : i);
      wr(COUNT_OFS, 32'h0);
      repeat (600) @(posedge aclk);
      rdr(COUNT_OFS);
      chk(rd, ((tr - tc - 3) >> ((i == 8) ? 0 : i + 1)) & 255);
    end
  endtask

  task automatic t_pin;
    for (int s = 0; s < 2; s++)
    begin
      wr(OPTION_OFS, 32'h28 | (s << 4));
      wr(COUNT_OFS, 32'h0);
      ext.level(1);
      rdr(COUNT_OFS);
      chk(rd, (s == 1) ? 0 : 1);
      ext.level(0);
      rdr(COUNT_OFS);
      chk(rd, 32'h1);
    end
  endtask

  // Flag sets while masked, irq follows mask, write-one clears
  task automatic t_ovf;
    wr(MASK_OFS, 32'h0);
    wr(OPTION_OFS, 32'h08);
    wr(COUNT_OFS, 32'hf0);
    repeat (30) @(posedge aclk);
    rdr(STATUS_OFS);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    wr(MASK_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(STATUS_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
  endtask

  task automatic t_misc;
    wr(CTRL_OFS, 32'h1);
    chk(br, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(nclr, 1);
    wr(8'h14, 32'h0);
    chk(br, RESP_SLVERR);
    rdr(8'h14);
    chk(rr, RESP_SLVERR);
    rdr(CTRL_OFS);
    chk(rd, 32'h0);
    rdr(OPTION_OFS);
    chk(rd, 32'h08);
  endtask

  // Watchdog owner at 1:4: clear restarts the prescaler, pulses follow ticks
  task automatic t_wd;
    wr(OPTION_OFS, 32'h0a);
    repeat (7) @(posedge aclk);
    wr(CTRL_OFS, 32'h1);
    t0 = ntick;
    @(posedge aclk);
    w0 = nwpt;
    repeat (200) @(posedge aclk);
    t1 = ntick;
    @(posedge aclk);
    chk(nwpt - w0, (t1 - t0) / 4);
    // Lane zero off: the write is answered but changes nothing
    wstrb <= 4'h0;
    wr(OPTION_OFS, 32'h22);
    wstrb <= 4'hf;
    rdr(OPTION_OFS);
    chk(rd, 32'h0a);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    finish_test;
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    t_reset;
    $display("reset done");
    t_rate;
    $display("rate done");
    t_pin;
    $display("pin done");
    t_ovf;
    $display("overflow done");
    t_misc;
    $display("misc done");
    t_wd;
    $display("watchdog done");
    finish_test;
  end
endmodule
